// [verilog/isbr_pkg.sv]
// constants and types shared by the interface, scratch and broadcast registers
package isbr_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ISBR_SETUP_OFS   = 8'h26;
    localparam logic [7:0] ISBR_POINTER_OFS = 8'h2b;
    localparam logic [7:0] ISBR_WORD_OFS    = 8'h2c;
    localparam logic [7:0] ISBR_CODE_OFS    = 8'h50;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ISBR_TIMEOUT_BIT  = 12;
    localparam int ISBR_RESERVED_BIT = 8;
    localparam int ISBR_FAST_BIT     = 2;
    localparam int ISBR_PIN_BIT      = 0;
    localparam int ISBR_CODE_LSB     = 4;

    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [15:0] ISBR_SETUP_RST   = 16'h0000;
    localparam logic [7:0]  ISBR_POINTER_RST = 8'h00;
    localparam logic [15:0] ISBR_WORD_RST    = 16'h0000;
    localparam logic [15:0] ISBR_CODE_RST    = 16'h0000;
    localparam int          ISBR_DAC_BITS    = 10;
    localparam int          ISBR_CHANNELS    = 3;

    // ------------------------------------------------------------------
    // register port request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } isbr_req_t;

endpackage

// [verilog/isbr_scratch_mem.sv]
// flip-flop scratch memory, one write port, combinational read by index
`timescale 1ns/100ps
module isbr_scratch_mem
    import isbr_pkg::*;
#(
    parameter int WIDTH     = 16,
    parameter int ADDR_BITS = 8
) (
    // clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 resetn_i,
    // access
    input  wire logic                 wr_en_i,
    input  wire logic [ADDR_BITS-1:0] addr_i,
    input  wire logic [WIDTH-1:0]     wdata_i,
    output logic      [WIDTH-1:0]     rdata_o
);

    localparam int DEPTH = 1 << ADDR_BITS;

    generate
        if (WIDTH != 16 || ADDR_BITS < 1 || ADDR_BITS > 8) begin : g_chk
            $error("isbr_scratch_mem: unsupported geometry");
        end
    endgenerate

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            next_mem[i] = mem[i];
        end
        if (wr_en_i) begin
            next_mem[addr_i] = wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= ISBR_WORD_RST;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= next_mem[i];
            end
        end
    end

    assign rdata_o = mem[addr_i];

endmodule

// [verilog/isbr_regs.sv]
// interface setup, scratch memory window and broadcast code registers
// Function
// - bit 12 of setup register enables bus timeout; zero after reset.
// - bit 2 of setup register selects fast serial output timing.
// - serial output drives shared pin only while setup bit 0 is one.
// - pointer register bits 7..0 pick the location for the next access.
// - each write through the word register advances the pointer by one.
// - word writes store 16 bits at pointer; reads return that word.
// - broadcast code is bits 15..4, msb aligned; bits 3..0 ignored.
// - 10-bit variant uses bits 15..6, 8-bit variant bits 15..8.
// - broadcast applies only to channels with follow enable set.
`timescale 1ns/100ps
module isbr_regs
    import isbr_pkg::*;
#(
    parameter int DAC_BITS = ISBR_DAC_BITS,
    parameter int CHANNELS = ISBR_CHANNELS
) (
    // clock and reset
    input  wire logic                clock_i,
    input  wire logic                resetn_i,
    // register port from the serial interface
    input  wire isbr_req_t           req_i,
    output logic      [15:0]         rdata_o,
    output logic                     rvalid_o,
    // serial interface control
    output logic                     timeout_enable_o,
    output logic                     fast_serial_output_enable_o,
    input  wire logic                serial_data_i,
    input  wire logic                serial_drive_i,
    output logic                     gpio_sdo_o,
    output logic                     gpio_sdo_oe_o,
    // broadcast to dac channels
    input  wire logic [CHANNELS-1:0] channel_follow_all_enable_i,
    output logic      [15:0]         channel_code_o,
    output logic      [CHANNELS-1:0] channel_load_o
);

    generate
        if ((DAC_BITS != 10 && DAC_BITS != 8) || CHANNELS < 1) begin : g_chk
            $error("isbr_regs: unsupported dac width or channel count");
        end
    endgenerate

    // all checks share this clock and stay quiet during reset
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // keeps only the msb-aligned code bits of the selected variant
    localparam logic [15:0] CODE_MASK = ~(16'hffff >> DAC_BITS);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic wr_setup;
    logic wr_pointer;
    logic wr_word;
    logic wr_code;
    logic rd_any;

    always_comb begin
        wr_setup   = 1'b0;
        wr_pointer = 1'b0;
        wr_word    = 1'b0;
        wr_code    = 1'b0;
        if (req_i.wr && req_i.addr == ISBR_SETUP_OFS) begin
            wr_setup = 1'b1;
        end else if (req_i.wr && req_i.addr == ISBR_POINTER_OFS) begin
            wr_pointer = 1'b1;
        end else if (req_i.wr && req_i.addr == ISBR_WORD_OFS) begin
            wr_word = 1'b1;
        end else if (req_i.wr && req_i.addr == ISBR_CODE_OFS) begin
            wr_code = 1'b1;
        end
        rd_any = req_i.rd && !req_i.wr;
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic                timeout_en;
    logic                reserved_bit;
    logic                fast_en;
    logic                pin_en;
    logic [7:0]          pointer;
    logic [11:0]         code;
    logic [15:0]         rdata;
    logic                rvalid;
    logic [15:0]         chan_code;
    logic [CHANNELS-1:0] chan_load;
    logic [15:0]         mem_rdata;

    logic                next_timeout_en;
    logic                next_reserved_bit;
    logic                next_fast_en;
    logic                next_pin_en;
    logic [7:0]          next_pointer;
    logic [11:0]         next_code;
    logic [15:0]         next_rdata;
    logic                next_rvalid;
    logic [15:0]         next_chan_code;
    logic [CHANNELS-1:0] next_chan_load;

    isbr_scratch_mem #(
        .WIDTH     (16),
        .ADDR_BITS (8)
    ) u_mem (
        .clock_i  (clock_i),
        .resetn_i (resetn_i),
        .wr_en_i  (wr_word),
        .addr_i   (pointer),
        .wdata_i  (req_i.wdata),
        .rdata_o  (mem_rdata)
    );

    always_comb begin
        next_timeout_en   = timeout_en;
        next_reserved_bit = reserved_bit;
        next_fast_en      = fast_en;
        next_pin_en       = pin_en;
        next_pointer      = pointer;
        next_code         = code;
        next_chan_code    = chan_code;
        next_chan_load    = '0;
        if (wr_setup) begin
            next_timeout_en   = req_i.wdata[ISBR_TIMEOUT_BIT];
            next_reserved_bit = req_i.wdata[ISBR_RESERVED_BIT];
            next_fast_en      = req_i.wdata[ISBR_FAST_BIT];
            next_pin_en       = req_i.wdata[ISBR_PIN_BIT];
        end
        if (wr_pointer) begin
            next_pointer = req_i.wdata[7:0];
        end
        // 8-bit add wraps 0xff to 0x00 by itself
        if (wr_word) begin
            next_pointer = pointer + 8'h01;
        end
        if (wr_code) begin
            next_code      = req_i.wdata[15:ISBR_CODE_LSB];
            next_chan_code = req_i.wdata & CODE_MASK;
            next_chan_load = channel_follow_all_enable_i;
        end
    end

    // ------------------------------------------------------------------
    // read path, registered so data lands one cycle after the request
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata  = 16'h0000;
        next_rvalid = rd_any;
        if (rd_any) begin
            if (req_i.addr == ISBR_SETUP_OFS) begin
                next_rdata[ISBR_TIMEOUT_BIT]  = timeout_en;
                next_rdata[ISBR_RESERVED_BIT] = reserved_bit;
                next_rdata[ISBR_FAST_BIT]     = fast_en;
                next_rdata[ISBR_PIN_BIT]      = pin_en;
            end else if (req_i.addr == ISBR_POINTER_OFS) begin
                next_rdata[7:0] = pointer;
            end else if (req_i.addr == ISBR_WORD_OFS) begin
                next_rdata = mem_rdata;
            end else if (req_i.addr == ISBR_CODE_OFS) begin
                next_rdata[15:ISBR_CODE_LSB] = code;
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timeout_en   <= ISBR_SETUP_RST[ISBR_TIMEOUT_BIT];
            reserved_bit <= ISBR_SETUP_RST[ISBR_RESERVED_BIT];
            fast_en      <= ISBR_SETUP_RST[ISBR_FAST_BIT];
            pin_en       <= ISBR_SETUP_RST[ISBR_PIN_BIT];
            pointer      <= ISBR_POINTER_RST;
            code         <= ISBR_CODE_RST[15:ISBR_CODE_LSB];
            rdata        <= 16'h0000;
            rvalid       <= 1'b0;
            chan_code    <= ISBR_CODE_RST;
            chan_load    <= '0;
        end else begin
            timeout_en   <= next_timeout_en;
            reserved_bit <= next_reserved_bit;
            fast_en      <= next_fast_en;
            pin_en       <= next_pin_en;
            pointer      <= next_pointer;
            code         <= next_code;
            rdata        <= next_rdata;
            rvalid       <= next_rvalid;
            chan_code    <= next_chan_code;
            chan_load    <= next_chan_load;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o                     = rdata;
    assign rvalid_o                    = rvalid;
    assign timeout_enable_o            = timeout_en;
    assign fast_serial_output_enable_o = fast_en;
    // pin stays released unless software hands it to the serial output
    assign gpio_sdo_oe_o               = pin_en & serial_drive_i;
    assign gpio_sdo_o                  = serial_data_i & gpio_sdo_oe_o;
    assign channel_code_o              = chan_code;
    assign channel_load_o              = chan_load;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    timeout_follows_a: assert property (
        wr_setup |=> timeout_enable_o == $past(req_i.wdata[ISBR_TIMEOUT_BIT]))
        else $error("timeout enable does not follow setup write");

    fast_follows_a: assert property (
        !wr_setup |=> $stable(fast_serial_output_enable_o))
        else $error("fast output mode changed without setup write");

    pin_gated_a: assert property (
        gpio_sdo_oe_o == (pin_en && serial_drive_i))
        else $error("shared pin drive does not follow its enable");

    pointer_load_a: assert property (
        wr_pointer |=> pointer == $past(req_i.wdata[7:0]))
        else $error("pointer write not taken");

    pointer_step_a: assert property (
        wr_word ##1 wr_word |=> pointer == $past(pointer, 2) + 8'h02)
        else $error("pointer did not advance on back to back writes");

    pointer_wrap_a: assert property (
        (wr_word && pointer == 8'hff) |=> pointer == 8'h00)
        else $error("pointer did not wrap");

    read_keeps_a: assert property (
        (rd_any && req_i.addr == ISBR_WORD_OFS) |=>
            $stable(pointer) && rdata_o == $past(mem_rdata))
        else $error("word read moved pointer or returned wrong data");

    // looks into the store itself, since the pointer has moved on
    word_roundtrip_a: assert property (
        wr_word |=> u_mem.mem[$past(pointer)] == $past(req_i.wdata))
        else $error("word write did not land at the pointer");

    code_mask_a: assert property (
        (channel_code_o & ~CODE_MASK) == 16'h0000)
        else $error("broadcast code carries ignored bits");

    load_only_enabled_a: assert property (
        wr_code |=> channel_load_o == $past(channel_follow_all_enable_i)
            && channel_code_o == ($past(req_i.wdata) & CODE_MASK))
        else $error("broadcast reached wrong channels or wrong code");

endmodule

// [dv/isbr_host_model.sv]
// host controller model that drives the register request port
`timescale 1ns/100ps
module isbr_host_model
    import isbr_pkg::*;
(
    // clock
    input  wire logic        clock_i,
    // request port
    output isbr_req_t        req_o,
    // read answer
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i
);
    initial begin
        req_o = '0;
    end

    // ------------------------------------------------------------------
    // bus release
    // ------------------------------------------------------------------
    // idle lines flip so a stale value is never mistaken for a request
    task automatic release_bus();
        req_o.wr    = 1'b0;
        req_o.rd    = 1'b0;
        req_o.addr  = ~req_o.addr;
        req_o.wdata = ~req_o.wdata;
    endtask

    // ------------------------------------------------------------------
    // register access, launched and released on the falling edge
    // ------------------------------------------------------------------
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] d);
        @(negedge clock_i);
        req_o.wr    = 1'b1;
        req_o.rd    = 1'b0;
        req_o.addr  = addr;
        req_o.wdata = d;
        if (addr == ISBR_SETUP_OFS) begin
            req_o.wdata[ISBR_RESERVED_BIT] = 1'b0;
        end
        @(negedge clock_i);
        release_bus();
    endtask

    // two writes on consecutive edges, strobe held up between them
    task automatic write_pair(input logic [7:0] addr, input logic [15:0] d0,
                              input logic [15:0] d1);
        @(negedge clock_i);
        req_o.wr    = 1'b1;
        req_o.rd    = 1'b0;
        req_o.addr  = addr;
        req_o.wdata = d0;
        @(negedge clock_i);
        req_o.wdata = d1;
        @(negedge clock_i);
        release_bus();
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [15:0] d,
                            output logic v);
        @(negedge clock_i);
        req_o.rd   = 1'b1;
        req_o.addr = addr;
        @(negedge clock_i);
        release_bus();
        v = rvalid_i;
        d = rdata_i;
    endtask
endmodule

// [dv/isbr_regs_tb.sv]
// self-checking bench for the interface, scratch and broadcast registers
`timescale 1ns/100ps
module isbr_regs_tb;
    import isbr_pkg::*;
    logic        clock_i;
    logic        resetn_i;
    isbr_req_t   req;
    logic [15:0] rdata;
    logic        rvalid;
    logic        timeout_en;
    logic        fast_en;
    logic        serial_data_i;
    logic        serial_drive_i;
    logic        sdo;
    logic        sdo_oe;
    logic [2:0]  follow;
    logic [15:0] code;
    logic [15:0] code8;
    logic [2:0]  load;
    int          n_fail;
    int          tests_run;

    // ------------------------------------------------------------------
    // instances
    // ------------------------------------------------------------------
    isbr_host_model host (.clock_i(clock_i), .req_o(req),
        .rdata_i(rdata), .rvalid_i(rvalid));
    isbr_regs dut (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .timeout_enable_o(timeout_en),
        .fast_serial_output_enable_o(fast_en),
        .serial_data_i(serial_data_i), .serial_drive_i(serial_drive_i),
        .gpio_sdo_o(sdo), .gpio_sdo_oe_o(sdo_oe),
        .channel_follow_all_enable_i(follow), .channel_code_o(code),
        .channel_load_o(load));
    // narrow variant shares the request port, only its code is watched
    isbr_regs #(.DAC_BITS(8)) dut8 (.clock_i(clock_i), .resetn_i(resetn_i),
        .req_i(req), .rdata_o(), .rvalid_o(), .timeout_enable_o(),
        .fast_serial_output_enable_o(), .serial_data_i(serial_data_i),
        .serial_drive_i(serial_drive_i), .gpio_sdo_o(), .gpio_sdo_oe_o(),
        .channel_follow_all_enable_i(follow), .channel_code_o(code8),
        .channel_load_o());

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        host.read_reg(addr, d, v);
        check({15'h0000, v}, 16'h0001);
        check(d, exp);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        #50000;
        n_fail++;
        conclude();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        n_fail = 0;
        tests_run = 0;
        resetn_i = 1'b0;
        serial_data_i = 1'b0;
        serial_drive_i = 1'b0;
        follow = 3'h0;
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        resetn_i = 1'b1;
        rd_chk(ISBR_SETUP_OFS, 16'h0000);
        rd_chk(ISBR_POINTER_OFS, 16'h0000);
        rd_chk(ISBR_WORD_OFS, 16'h0000);
        rd_chk(ISBR_CODE_OFS, 16'h0000);
        check({15'h0000, timeout_en}, 16'h0000);
        // setup: don't-care bits read zero, reserved bit always written as zero
        host.write_reg(ISBR_SETUP_OFS, 16'hffff);
        check({15'h0000, timeout_en}, 16'h0001);
        check({15'h0000, fast_en}, 16'h0001);
        rd_chk(ISBR_SETUP_OFS, 16'h1005);
        serial_drive_i = 1'b1;
        serial_data_i = 1'b1;
        #1 check({14'h0000, sdo_oe, sdo}, 16'h0003);
        serial_data_i = 1'b0;
        #1 check({14'h0000, sdo_oe, sdo}, 16'h0002);
        host.write_reg(ISBR_SETUP_OFS, 16'h0004);
        serial_data_i = 1'b1;
        #1 check({13'h0000, timeout_en, fast_en, sdo_oe}, 16'h0002);
        // scratch memory: fill across the wrap point
        host.write_reg(ISBR_POINTER_OFS, 16'hfffe);
        rd_chk(ISBR_POINTER_OFS, 16'h00fe);
        for (int i = 0; i < 3; i++) begin
            host.write_reg(ISBR_WORD_OFS, 16'ha5a0 + 16'(i));
        end
        rd_chk(ISBR_POINTER_OFS, 16'h0001);
        host.write_reg(ISBR_POINTER_OFS, 16'h00fe);
        rd_chk(ISBR_WORD_OFS, 16'ha5a0);
        rd_chk(ISBR_WORD_OFS, 16'ha5a0);
        rd_chk(ISBR_POINTER_OFS, 16'h00fe);
        host.write_reg(ISBR_POINTER_OFS, 16'h00ff);
        rd_chk(ISBR_WORD_OFS, 16'ha5a1);
        host.write_reg(ISBR_POINTER_OFS, 16'h0000);
        rd_chk(ISBR_WORD_OFS, 16'ha5a2);
        // back-to-back word writes step the pointer twice
        host.write_reg(ISBR_POINTER_OFS, 16'h0010);
        host.write_pair(ISBR_WORD_OFS, 16'h1111, 16'h2222);
        rd_chk(ISBR_POINTER_OFS, 16'h0012);
        host.write_reg(ISBR_POINTER_OFS, 16'h0011);
        rd_chk(ISBR_WORD_OFS, 16'h2222);
        host.write_reg(8'h31, 16'h1234);
        rd_chk(8'h31, 16'h0000);
        // broadcast to following channels only
        follow = 3'h5;
        host.write_reg(ISBR_CODE_OFS, 16'hffff);
        check(code, 16'hffc0);
        check(code8, 16'hff00);
        check({13'h0000, load}, 16'h0005);
        @(negedge clock_i);
        check({13'h0000, load}, 16'h0000);
        rd_chk(ISBR_CODE_OFS, 16'hfff0);
        follow = 3'h0;
        host.write_reg(ISBR_CODE_OFS, 16'h123f);
        check(code, 16'h1200);
        check({13'h0000, load}, 16'h0000);
        // mid-run reset must clear everything written so far
        resetn_i = 1'b0;
        repeat (2) @(negedge clock_i);
        resetn_i = 1'b1;
        check({14'h0000, timeout_en, fast_en}, 16'h0000);
        check(code, 16'h0000);
        rd_chk(ISBR_POINTER_OFS, 16'h0000);
        rd_chk(ISBR_CODE_OFS, 16'h0000);
        conclude();
    end
endmodule
